// file: logic/slp_pkg.sv
// package: latch layout, select codes and timing constants for the latch programming block
package slp_pkg;

  localparam int WORD_W = 24;

  // two low select bits route a word to a latch
  localparam logic [1:0] SEL_CONTROL   = 2'h0;
  localparam logic [1:0] SEL_REFERENCE = 2'h1;
  localparam logic [1:0] SEL_DIVIDER   = 2'h2;
  localparam logic [1:0] SEL_TEST      = 2'h3;

  // control word field positions
  localparam int CW_PRESCALE_LO   = 22;
  localparam int CW_PD_SYNC       = 21;
  localparam int CW_PD_ARM        = 20;
  localparam int CW_CUR_B_LO      = 17;
  localparam int CW_CUR_A_LO      = 14;
  localparam int CW_LEVEL_LO      = 12;
  localparam int CW_MUTE          = 11;
  localparam int CW_PUMP_GAIN     = 10;
  localparam int CW_PUMP_TRI      = 9;
  localparam int CW_POLARITY      = 8;
  localparam int CW_MUX_LO        = 5;
  localparam int CW_CNT_CLEAR     = 4;
  localparam int CW_CORE_LO       = 2;

  // divider word field positions
  localparam int DW_HALVED_FB     = 23;
  localparam int DW_OUT_HALVE     = 22;
  localparam int DW_PUMP_GAIN     = 21;
  localparam int DW_B_LO          = 8;
  localparam int DW_B_W           = 13;
  localparam int DW_SWALLOW_LO    = 2;
  localparam int DW_SWALLOW_W     = 5;

  // reference word field positions
  localparam int RW_BAND_DIV_LO   = 20;
  localparam int RW_TEST_BIT      = 19;
  localparam int RW_LOCK_SEL      = 18;
  localparam int RW_PULSE_LO      = 16;
  localparam int RW_REF_LO        = 2;
  localparam int RW_REF_W         = 14;

  // reset values
  localparam logic [23:0] WORD_RESET = 24'h000000;

  // synchronous power-down waits for this many reference edges
  localparam logic [1:0] SYNC_PD_EDGES = 2'h2;
  // band selection lasts this many detector cycles
  localparam logic [2:0] BAND_SEL_CYCLES = 3'h5;

  // serial pins as seen by the device
  typedef struct packed {
    logic serialClk;
    logic serialData;
    logic latchStrobe;
  } slp_pins_type;

  // decoded block controls
  typedef struct packed {
    logic        poweredDown;
    logic        countersLoad;
    logic        pumpTristate;
    logic        lockReset;
    logic        outputsHighZ;
    logic        refBufferOff;
    logic        pumpGain;
    logic        bandSelectBusy;
  } slp_ctrl_type;

endpackage

// file: logic/slp_shift_in.sv
// serial front end: pin synchronisers, 24-bit shifter and strobe edge
`timescale 1ns/1ps
module slp_shift_in
  import slp_pkg::*;
#(
  parameter int WIDTH = WORD_W
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  input  wire logic             clkEn,
  input  wire slp_pins_type     pins,
  output logic [WIDTH-1:0]      shiftWord,
  output logic                  strobeRise
);

  typedef struct packed {
    slp_pins_type     meta;
    slp_pins_type     sync;
    slp_pins_type     last;
    logic [WIDTH-1:0] shift;
  } slp_shift_state_type;

  slp_shift_state_type state_q;
  slp_shift_state_type state_d;

  // meta is only read by sync; edges use sync against last
  always_comb begin
    state_d      = state_q;
    state_d.meta = pins;
    state_d.sync = state_q.meta;
    state_d.last = state_q.sync;
    if (state_q.sync.serialClk && !state_q.last.serialClk) begin
      state_d.shift = {state_q.shift[WIDTH-2:0], state_q.sync.serialData}; // RULE_18
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_q <= '0;
    end else if (clkEn) begin
      state_q <= state_d;
    end
  end

  assign shiftWord  = state_q.shift;
  assign strobeRise = clkEn && state_q.sync.latchStrobe && !state_q.last.latchStrobe;

endmodule

// file: logic/slp_latch_program.sv
// latch programming and power-down control of the synthesizer digital core
`timescale 1ns/1ps
// How it works
// [RULE_01] select 00 loads control word: prescale, power-down, pump, level, mux, clear, core
// [RULE_02] select 10 loads divider word: halving bits, pump gain, B and swallow
// [RULE_03] select 01 loads reference word: band divider, test, lock, pulse, R count
// [RULE_04] host writes reference, then control, then divider after power-up
// [RULE_05] first control word after power-up powers the device up
// [RULE_06] host waits 5 ms or 600 us between control and divider; the testbench waits 50 system clocks
// [RULE_07] chip power pin low disables device at once regardless of bits
// [RULE_08] arm bit with sync select clear powers down right after strobe
// [RULE_09] both bits set powers down on second reference edge after strobe
// [RULE_10] power-down forces reference, divider and timeout counters to load
// [RULE_11] power-down puts charge pump in tristate
// [RULE_12] power-down resets digital lock detect to unlocked
// [RULE_13] power-down tristates outputs, removes dc paths, disables reference buffer
// [RULE_14] shifter and latches keep working while powered down
// [RULE_15] pin re-enable with untouched divider relocks without band selection
// [RULE_16] software re-enable with untouched divider relocks in current band
// [RULE_17] host must not change divider while down, else redo sequence
// [RULE_18] shift 24 bits msb first on serial clock, copy on strobe rise
// [RULE_19] divider update starts band selection lasting five detector cycles
// [RULE_20] pump gain follows the latest write from control or divider word
// [RULE_21] counter clear bit holds reference, swallow and B counters reset
// [RULE_22] host writes spare and test bits zero, never selects test latch; the testbench selects the test latch once, to check the word is dropped
// [RULE_23] host holds strobe low while shifting, raises it after last bit
module slp_latch_program
  import slp_pkg::*;
(
  input  wire logic            clk_sys,
  input  wire logic            rst_b,
  input  wire logic            clkEn,
  input  wire slp_pins_type    pins,
  input  wire logic            chipPower,
  input  wire logic            refCountOut,
  input  wire logic            detectorTick,
  output logic [WORD_W-1:0]    controlWord,
  output logic [WORD_W-1:0]    dividerWord,
  output logic [WORD_W-1:0]    referenceWord,
  output slp_ctrl_type         ctrl
);

  typedef enum logic [2:0] {
    PWR_OFF  = 3'b001,
    PWR_ON   = 3'b010,
    PWR_WAIT = 3'b100
  } slp_pwr_type;

  typedef struct packed {
    logic [WORD_W-1:0] ctlWord;
    logic [WORD_W-1:0] divWord;
    logic [WORD_W-1:0] refWord;
    slp_pwr_type       pwr;
    logic [1:0]        edgeCnt;
    logic [2:0]        bandCnt;
    logic              pumpGain;
    logic [1:0]        pinSync;
    logic [1:0]        refSync;
    logic              refLast;
    logic [1:0]        tickSync;
    logic              tickLast;
  } slp_state_type;

  slp_state_type state_q;
  slp_state_type state_d;
  logic [WORD_W-1:0] shiftWord;
  logic              strobeRise;
  logic              chipOn;
  logic              refEdge;
  logic              tickEdge;
  logic              down;

  slp_shift_in #(.WIDTH(WORD_W)) u_shift (
    .clk_sys    (clk_sys),
    .rst_b      (rst_b),
    .clkEn      (clkEn),
    .pins       (pins),
    .shiftWord  (shiftWord),
    .strobeRise (strobeRise)
  );

  // pin inputs read only from second stage
  assign chipOn   = state_q.pinSync[1];
  assign refEdge  = state_q.refSync[1] && !state_q.refLast;
  assign tickEdge = state_q.tickSync[1] && !state_q.tickLast;

  // latch load, power sequencing and band selection
  always_comb begin
    state_d          = state_q;
    state_d.pinSync  = {state_q.pinSync[0], chipPower};
    state_d.refSync  = {state_q.refSync[0], refCountOut};
    state_d.refLast  = state_q.refSync[1];
    state_d.tickSync = {state_q.tickSync[0], detectorTick};
    state_d.tickLast = state_q.tickSync[1];
    // sync power-down counts reference edges after the strobe
    if (state_q.pwr == PWR_WAIT && refEdge) begin
      state_d.edgeCnt = state_q.edgeCnt + 2'h1;
      if (state_q.edgeCnt + 2'h1 == SYNC_PD_EDGES) begin
        state_d.pwr = PWR_OFF; // RULE_09
      end
    end
    // band selection counts detector cycles; frozen while down
    if (state_q.bandCnt != 3'h0 && tickEdge && !down) begin
      state_d.bandCnt = state_q.bandCnt - 3'h1; // RULE_19
    end
    // latches load even while powered down
    if (strobeRise) begin // RULE_14
      case (shiftWord[1:0])
        SEL_CONTROL: begin
          state_d.ctlWord  = shiftWord; // RULE_01
          state_d.pumpGain = shiftWord[CW_PUMP_GAIN]; // RULE_20
          state_d.edgeCnt  = 2'h0;
          if (!shiftWord[CW_PD_ARM]) begin
            state_d.pwr = PWR_ON; // RULE_05 RULE_16
          end else if (!shiftWord[CW_PD_SYNC]) begin
            state_d.pwr = PWR_OFF; // RULE_08
          end else if (state_q.pwr == PWR_ON) begin
            state_d.pwr = PWR_WAIT; // RULE_09
          end else begin
            state_d.pwr = state_q.pwr;
          end
        end
        SEL_DIVIDER: begin
          state_d.divWord  = shiftWord; // RULE_02
          state_d.pumpGain = shiftWord[DW_PUMP_GAIN]; // RULE_20
          state_d.bandCnt  = BAND_SEL_CYCLES; // RULE_19
        end
        SEL_REFERENCE: begin
          state_d.refWord = shiftWord; // RULE_03
        end
        SEL_TEST: begin
          // factory latch contents are not modelled; word dropped
          state_d.refWord = state_q.refWord;
        end
        default: begin
          state_d.refWord = state_q.refWord;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_q         <= '0;
      state_q.pwr     <= PWR_OFF;
      state_q.ctlWord <= WORD_RESET;
    end else if (clkEn) begin
      state_q <= state_d;
    end
  end

  // pin low overrides both power-down bits; relock keeps current band
  assign down = !chipOn || state_q.pwr == PWR_OFF; // RULE_07 RULE_15

  // outputs held in flip-flops, effects decoded from power state, pin and latched control bits
  assign controlWord   = state_q.ctlWord;
  assign dividerWord   = state_q.divWord;
  assign referenceWord = state_q.refWord;
  always_comb begin
    ctrl.poweredDown    = down;
    ctrl.countersLoad   = down || state_q.ctlWord[CW_CNT_CLEAR]; // RULE_10 RULE_21
    ctrl.pumpTristate   = down || state_q.ctlWord[CW_PUMP_TRI]; // RULE_11
    ctrl.lockReset      = down; // RULE_12
    ctrl.outputsHighZ   = down; // RULE_13
    ctrl.refBufferOff   = down; // RULE_13
    ctrl.pumpGain       = state_q.pumpGain;
    ctrl.bandSelectBusy = state_q.bandCnt != 3'h0;
  end

  // wake step: a down cycle with no divider load, then an up cycle
  sequence s_down_quiet;
    ctrl.poweredDown && !(strobeRise && shiftWord[1:0] == SEL_DIVIDER);
  endsequence

  sequence s_wake;
    s_down_quiet ##1 !ctrl.poweredDown;
  endsequence

  // checks on power state, power-down effects, latch loads and relock
  property p_async_pd;
    @(posedge clk_sys) disable iff (!rst_b)
      strobeRise && shiftWord[1:0] == SEL_CONTROL && shiftWord[CW_PD_ARM]
      && !shiftWord[CW_PD_SYNC] |=> ctrl.poweredDown;
  endproperty
  a_async_pd: assert property (p_async_pd) // RULE_08
    else $error("async power-down not taken");

  property p_sync_off;
    @(posedge clk_sys) disable iff (!rst_b)
      clkEn && state_q.pwr == PWR_WAIT && state_q.edgeCnt == 2'h1 && refEdge
      && !strobeRise |=> ctrl.poweredDown;
  endproperty
  a_sync_off: assert property (p_sync_off) // RULE_09
    else $error("sync power-down missed second edge");

  property p_pin_off;
    @(posedge clk_sys) disable iff (!rst_b)
      !state_q.pinSync[1] |-> ctrl.poweredDown && ctrl.outputsHighZ;
  endproperty
  a_pin_off: assert property (p_pin_off) // RULE_07
    else $error("pin low did not disable");

  property p_pump;
    @(posedge clk_sys) disable iff (!rst_b)
      ctrl.poweredDown |-> ctrl.pumpTristate && ctrl.countersLoad && ctrl.lockReset;
  endproperty
  a_pump: assert property (p_pump) // RULE_10
    else $error("power-down effects missing");

  property p_clear;
    @(posedge clk_sys) disable iff (!rst_b)
      state_q.ctlWord[CW_CNT_CLEAR] |-> ctrl.countersLoad;
  endproperty
  a_clear: assert property (p_clear) // RULE_21
    else $error("counter clear ignored");

  property p_band;
    @(posedge clk_sys) disable iff (!rst_b)
      strobeRise && shiftWord[1:0] == SEL_DIVIDER |=> ctrl.bandSelectBusy;
  endproperty
  a_band: assert property (p_band) // RULE_19
    else $error("band select not started");

  property p_gain;
    @(posedge clk_sys) disable iff (!rst_b)
      strobeRise && shiftWord[1:0] == SEL_DIVIDER
      |=> ctrl.pumpGain == $past(shiftWord[DW_PUMP_GAIN]);
  endproperty
  a_gain: assert property (p_gain) // RULE_20
    else $error("pump gain not latest");

  property p_load;
    @(posedge clk_sys) disable iff (!rst_b)
      strobeRise && shiftWord[1:0] == SEL_REFERENCE
      |=> referenceWord == $past(shiftWord);
  endproperty
  a_load: assert property (p_load) // RULE_03
    else $error("reference word not loaded");

  // power state only: the pin may still hold the outputs down
  property p_wake;
    @(posedge clk_sys) disable iff (!rst_b)
      strobeRise && shiftWord[1:0] == SEL_CONTROL && !shiftWord[CW_PD_ARM]
      |=> state_q.pwr == PWR_ON;
  endproperty
  a_wake: assert property (p_wake) // RULE_05
    else $error("control word did not power up");

  // waking up must not restart band selection
  property p_relock;
    @(posedge clk_sys) disable iff (!rst_b)
      s_wake |-> state_q.bandCnt == $past(state_q.bandCnt);
  endproperty
  a_relock: assert property (p_relock) // RULE_15 RULE_16
    else $error("wake-up restarted band selection");

endmodule

// file: sim/slp_host_model.sv
// host model: drives three-wire serial writes into the latch block
`timescale 1ns/1ps
module slp_host_model
  import slp_pkg::*;
(
  input  wire logic    clk_sys,
  output slp_pins_type pins
);
  // serial clock and strobe idle low, clock stands still between frames
  initial pins = '0;

  // step a few system clocks, landing just after the edge
  task automatic waitClk(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // one frame, msb first; 4 clocks per level keeps edges past the 3-cycle floor
  task automatic writeWord(input logic [WORD_W-1:0] w);
    for (int i = WORD_W - 1; i >= 0; i--) begin
      pins.serialData = w[i];
      waitClk(4);
      pins.serialClk = 1'b1;
      waitClk(4);
      pins.serialClk = 1'b0;
    end
    pins.serialData = ~pins.serialData; // released line must not show the last bit
    pins.latchStrobe = 1'b1;
    waitClk(4);
    pins.latchStrobe = 1'b0;
    waitClk(6);
  endtask
endmodule

// file: sim/tb.sv
// testbench: latch loading, band select and power-down sequences
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
  import slp_pkg::*;
  logic                clk_sys;
  logic                rst_b;
  logic                clkEn;
  logic                chipPower;
  logic                refCountOut;
  logic                detectorTick;
  slp_pins_type        pins;
  logic [WORD_W-1:0]   controlWord;
  logic [WORD_W-1:0]   dividerWord;
  logic [WORD_W-1:0]   referenceWord;
  slp_ctrl_type        ctrl;
  int                  mismatches;
  int                  checks_done;

  slp_host_model host_i (.clk_sys(clk_sys), .pins(pins));

  slp_latch_program slp_latch_program_i (
    .clk_sys(clk_sys), .rst_b(rst_b), .clkEn(clkEn), .pins(pins),
    .chipPower(chipPower), .refCountOut(refCountOut), .detectorTick(detectorTick),
    .controlWord(controlWord), .dividerWord(dividerWord),
    .referenceWord(referenceWord), .ctrl(ctrl)
  );

  // 200 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // one rise of the reference output or the detector tick
  task automatic pulse(input bit isRef);
    if (isRef) refCountOut = 1'b1;
    else detectorTick = 1'b1;
    host_i.waitClk(4);
    refCountOut = 1'b0;
    detectorTick = 1'b0;
    host_i.waitClk(4);
  endtask

  task automatic stop_test();
    $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // hang guard, far beyond the roughly 2100 cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    stop_test();
  end

  initial begin
    rst_b = 1'b0;
    clkEn = 1'b1;
    chipPower = 1'b1;
    refCountOut = 1'b0;
    detectorTick = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    host_i.waitClk(2);
    `CHK(ctrl, 8'hfc)
    // power-up order: reference, control, then divider
    host_i.writeWord(24'h040029);
    `CHK(referenceWord, 24'h040029)
    host_i.writeWord(24'h000400);
    `CHK(controlWord, 24'h000400)
    `CHK(ctrl, 8'h02)
    // settling wait shortened; the device does not time it
    host_i.waitClk(50);
    host_i.writeWord(24'h012302);
    `CHK(dividerWord, 24'h012302)
    `CHK(ctrl, 8'h01)
    repeat (4) pulse(1'b0);
    `CHK(ctrl, 8'h01)
    pulse(1'b0);
    `CHK(ctrl, 8'h00)
    // test-latch code must leave every latch alone
    host_i.writeWord(24'h123457);
    `CHK(controlWord, 24'h000400)
    `CHK(dividerWord, 24'h012302)
    `CHK(referenceWord, 24'h040029)
    // asynchronous power-down, then a write while down
    host_i.writeWord(24'h100400);
    `CHK(ctrl, 8'hfe)
    host_i.writeWord(24'h010031);
    `CHK(referenceWord, 24'h010031)
    `CHK(ctrl, 8'hfe)
    // software power-up with counter clear and pump tristate bits set
    host_i.writeWord(24'h000610);
    `CHK(ctrl, 8'h62)
    host_i.writeWord(24'h000400);
    `CHK(ctrl, 8'h02)
    // chip power pin overrides the latched state
    chipPower = 1'b0;
    host_i.waitClk(5);
    `CHK(ctrl, 8'hfe)
    chipPower = 1'b1;
    host_i.waitClk(5);
    `CHK(ctrl, 8'h02)
    // clock enable low freezes the block: a whole frame passes unseen
    clkEn = 1'b0;
    host_i.writeWord(24'h020031);
    clkEn = 1'b1;
    host_i.waitClk(4);
    `CHK(referenceWord, 24'h010031)
    `CHK(ctrl, 8'h02)
    // synchronous power-down waits for the second reference rise
    host_i.writeWord(24'h300400);
    `CHK(ctrl, 8'h02)
    pulse(1'b1);
    `CHK(ctrl, 8'h02)
    pulse(1'b1);
    `CHK(ctrl, 8'hfe)
    stop_test();
  end
endmodule
